// >>> rtl/gpc_port.sv
// Operation
// - Pull-up enable bit per pin, valid for any owner.
// - Ownership bit one gives pin to controller, zero to peripheral.
// - Two mux select bits choose one of four peripheral functions.
// - Peripheral owner decides drive enable and driven level.
// - Controller owner drives pin only when drive-enable bit is one.
// - Pin level follows output level register; aliases act alike.
// - Open-drain bit makes pin only pull low, any owner.
// - Pin value readback returns actual line level.
// - Readback and interrupt input live only when owned or interrupt enabled; peripherals always see the raw pin.
// - Any-change, rising or falling interrupt detection per pin.
// - Interrupt enable bit per pin, regardless of owner.
// - Detected enabled event raises the request.
// - Four request lines, each OR of eight pins.
// - Sticky flags per pin, cleared by software write.
// - Detection only on clock edges; gated clock means no request.
// - Filter rejects sub-cycle glitches, accepts two-cycle pulses.
// - Enabled filter adds one cycle latency.
// - Filter enable bit per pin, bypass when clear.
// - Filter only on interrupt path, not readback or peripherals.
// - Unfiltered input counts only when present at clock edge.
// - Filtered input needs equal level on two consecutive edges.
// - Ports of 32 pins, one bit per pin per register.
`timescale 1ns/100ps
`default_nettype none
module gpc_port #(
   parameter int NPINS = 32
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire gpc_pkg::gpc_bus_t bus,
   output logic [31:0] rdata,
   input wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe,
   output logic [NPINS-1:0] pin_pullup,
   input wire logic [NPINS-1:0] periph_out0,
   input wire logic [NPINS-1:0] periph_out1,
   input wire logic [NPINS-1:0] periph_out2,
   input wire logic [NPINS-1:0] periph_out3,
   input wire logic [NPINS-1:0] periph_oe0,
   input wire logic [NPINS-1:0] periph_oe1,
   input wire logic [NPINS-1:0] periph_oe2,
   input wire logic [NPINS-1:0] periph_oe3,
   output logic [NPINS-1:0] periph_in,
   output logic [3:0] irq
);
   // ==========================================================
   // Register write decode
   // 32-bit registers, one bit per pin
   function automatic logic [NPINS-1:0] upd(input logic [NPINS-1:0] cur, input logic [7:0] base,
                                            input gpc_pkg::gpc_bus_t b);
      logic [NPINS-1:0] d;
      logic [NPINS-1:0] r;
      d = b.wdata[NPINS-1:0];
      r = cur;
      if (b.wr && b.addr[7:4] == base[7:4] && b.addr[1:0] == 2'h0)
      begin
         case (b.addr[3:2])
            gpc_pkg::ALIAS_WRITE: r = d;
            gpc_pkg::ALIAS_SET: r = cur | d;
            gpc_pkg::ALIAS_CLEAR: r = cur & ~d;
            gpc_pkg::ALIAS_TOGGLE: r = cur ^ d;
            default: r = cur;
         endcase
      end
      return r;
   endfunction

   logic [NPINS-1:0] owner_ff;
   logic [NPINS-1:0] mux_lo_ff;
   logic [NPINS-1:0] mux_hi_ff;
   logic [NPINS-1:0] drive_ff;
   logic [NPINS-1:0] level_ff;
   logic [NPINS-1:0] pullup_ff;
   logic [NPINS-1:0] odrain_ff;
   logic [NPINS-1:0] irqen_ff;
   logic [NPINS-1:0] mode_lo_ff;
   logic [NPINS-1:0] mode_hi_ff;
   logic [NPINS-1:0] filter_ff;
   logic [NPINS-1:0] flags_ff;
   logic [NPINS-1:0] samp_ff;
   logic [NPINS-1:0] filt_ff;
   logic [NPINS-1:0] prev_ff;
   logic [31:0] rdata_ff;
   logic [NPINS-1:0] nxt_flags;
   logic [NPINS-1:0] det_in;
   logic [NPINS-1:0] rise;
   logic [NPINS-1:0] fall;
   logic [NPINS-1:0] event_hit;
   logic [NPINS-1:0] sel_out;
   logic [NPINS-1:0] sel_oe;
   logic [NPINS-1:0] drv_oe;
   logic [NPINS-1:0] drv_val;
   logic [NPINS-1:0] in_live;
   logic [31:0] nxt_rdata;
   wire logic flags_wr = bus.wr && bus.addr == gpc_pkg::OFS_FLAGS;

   // ==========================================================
   // Next values, each register decoded by its own base
   wire logic [NPINS-1:0] nxt_owner = upd(owner_ff, gpc_pkg::OFS_OWNER, bus);
   wire logic [NPINS-1:0] nxt_mux_lo = upd(mux_lo_ff, gpc_pkg::OFS_MUX_LO, bus);
   wire logic [NPINS-1:0] nxt_mux_hi = upd(mux_hi_ff, gpc_pkg::OFS_MUX_HI, bus);
   wire logic [NPINS-1:0] nxt_drive = upd(drive_ff, gpc_pkg::OFS_DRIVE, bus);
   wire logic [NPINS-1:0] nxt_level = upd(level_ff, gpc_pkg::OFS_LEVEL, bus);
   wire logic [NPINS-1:0] nxt_pullup = upd(pullup_ff, gpc_pkg::OFS_PULLUP, bus);
   wire logic [NPINS-1:0] nxt_odrain = upd(odrain_ff, gpc_pkg::OFS_ODRAIN, bus);
   wire logic [NPINS-1:0] nxt_irqen = upd(irqen_ff, gpc_pkg::OFS_IRQEN, bus);
   wire logic [NPINS-1:0] nxt_mode_lo = upd(mode_lo_ff, gpc_pkg::OFS_MODE_LO, bus);
   wire logic [NPINS-1:0] nxt_mode_hi = upd(mode_hi_ff, gpc_pkg::OFS_MODE_HI, bus);
   wire logic [NPINS-1:0] nxt_filter = upd(filter_ff, gpc_pkg::OFS_FILTER, bus);

   // ==========================================================
   // Configuration registers
   // Ownership, controller by default
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         owner_ff <= gpc_pkg::RST_ALL_ONES[NPINS-1:0];
      else
         owner_ff <= nxt_owner;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         mux_lo_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         mux_lo_ff <= nxt_mux_lo;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         mux_hi_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         mux_hi_ff <= nxt_mux_hi;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         drive_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         drive_ff <= nxt_drive;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         level_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         level_ff <= nxt_level;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         pullup_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         pullup_ff <= nxt_pullup;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         odrain_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         odrain_ff <= nxt_odrain;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         irqen_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         irqen_ff <= nxt_irqen;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         mode_lo_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         mode_lo_ff <= nxt_mode_lo;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         mode_hi_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         mode_hi_ff <= nxt_mode_hi;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         filter_ff <= gpc_pkg::RST_ALL_ONES[NPINS-1:0];
      else
         filter_ff <= nxt_filter;
   end

   // ==========================================================
   // Per-pin output path and event detection
   genvar i;
   generate
      for (i = 0; i < NPINS; i++)
      begin : g_pin
         wire logic [1:0] msel = {mux_hi_ff[i], mux_lo_ff[i]};
         wire logic [1:0] mode = {mode_hi_ff[i], mode_lo_ff[i]};
         assign sel_out[i] = msel == 2'h0 ? periph_out0[i] : msel == 2'h1 ? periph_out1[i] :
                             msel == 2'h2 ? periph_out2[i] : periph_out3[i];
         assign sel_oe[i] = msel == 2'h0 ? periph_oe0[i] : msel == 2'h1 ? periph_oe1[i] :
                            msel == 2'h2 ? periph_oe2[i] : periph_oe3[i];
         assign drv_oe[i] = owner_ff[i] ? drive_ff[i] : sel_oe[i];
         assign drv_val[i] = owner_ff[i] ? level_ff[i] : sel_out[i];
         assign pin_oe[i] = drv_oe[i] && !(odrain_ff[i] && drv_val[i]);
         assign pin_out[i] = odrain_ff[i] ? 1'b0 : drv_val[i];
         assign det_in[i] = filter_ff[i] ? filt_ff[i] : samp_ff[i];
         assign rise[i] = det_in[i] && !prev_ff[i];
         assign fall[i] = !det_in[i] && prev_ff[i];
         // Mode decode, reserved code never fires
         assign event_hit[i] = mode == gpc_pkg::MODE_CHANGE ? (rise[i] | fall[i]) :
                               mode == gpc_pkg::MODE_RISE ? rise[i] :
                               mode == gpc_pkg::MODE_FALL ? fall[i] : 1'b0;
      end
   endgenerate

   assign pin_pullup = pullup_ff;
   assign in_live = owner_ff | irqen_ff;
   assign periph_in = pin_in;

   // Gated level now, and per pin whether it matches the last sample
   wire logic [NPINS-1:0] in_now = pin_in & in_live;
   wire logic [NPINS-1:0] same = ~(samp_ff ^ in_now);

   // ==========================================================
   // Input sampling and glitch filter
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         samp_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
         filt_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
         prev_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      end
      else
      begin
         // Level taken at the clock edge
         samp_ff <= in_now;
         // Equal level on two edges updates filter
         filt_ff <= (same & samp_ff) | (~same & filt_ff);
         // Detector input of the last edge, per pin
         prev_ff <= det_in;
      end
   end

   // ==========================================================
   // Sticky flags, event wins over clear
   // Enabled events latch until cleared
   wire logic [NPINS-1:0] flag_keep = flags_wr ? flags_ff & ~bus.wdata[NPINS-1:0] : flags_ff;
   wire logic [NPINS-1:0] flag_set = event_hit & irqen_ff;
   assign nxt_flags = flag_keep | flag_set;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         flags_ff <= gpc_pkg::RST_ZERO[NPINS-1:0];
      else
         flags_ff <= nxt_flags;
   end

   // Groups of eight ORed per line
   // Enable gates each line, so masking needs no flag write
   generate
      for (i = 0; i < 4; i++)
      begin : g_irq
         if (i * gpc_pkg::PINS_PER_LINE < NPINS)
         begin : g_on
            localparam int HI = (i + 1) * gpc_pkg::PINS_PER_LINE > NPINS ? NPINS - 1 :
                                (i + 1) * gpc_pkg::PINS_PER_LINE - 1;
            assign irq[i] = |(flags_ff[HI:i * gpc_pkg::PINS_PER_LINE] & irqen_ff[HI:i * gpc_pkg::PINS_PER_LINE]);
         end
         else
         begin : g_off
            assign irq[i] = 1'b0;
         end
      end
   endgenerate

   // ==========================================================
   // Read path, data one cycle after strobe
   logic [NPINS-1:0] rsel;
   always_comb
   begin
      rsel = '0;
      case (bus.addr)
         gpc_pkg::OFS_OWNER: rsel = owner_ff;
         gpc_pkg::OFS_MUX_LO: rsel = mux_lo_ff;
         gpc_pkg::OFS_MUX_HI: rsel = mux_hi_ff;
         gpc_pkg::OFS_DRIVE: rsel = drive_ff;
         gpc_pkg::OFS_LEVEL: rsel = level_ff;
         // Actual level, only where input is live
         gpc_pkg::OFS_PINVAL: rsel = pin_in & in_live;
         gpc_pkg::OFS_PULLUP: rsel = pullup_ff;
         gpc_pkg::OFS_ODRAIN: rsel = odrain_ff;
         gpc_pkg::OFS_IRQEN: rsel = irqen_ff;
         gpc_pkg::OFS_MODE_LO: rsel = mode_lo_ff;
         gpc_pkg::OFS_MODE_HI: rsel = mode_hi_ff;
         gpc_pkg::OFS_FILTER: rsel = filter_ff;
         gpc_pkg::OFS_FLAGS: rsel = flags_ff;
         default: rsel = '0;
      endcase
      nxt_rdata = '0;
      nxt_rdata[NPINS-1:0] = rsel;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_ff <= gpc_pkg::RST_ZERO;
      else
         rdata_ff <= bus.rd ? nxt_rdata : gpc_pkg::RST_ZERO;
   end
   // Zero outside the read cycle keeps the bus quiet
   assign rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> rtl/gpc_pkg.sv
`default_nettype none
package gpc_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_OWNER = 8'h00;
   localparam logic [7:0] OFS_MUX_LO = 8'h10;
   localparam logic [7:0] OFS_MUX_HI = 8'h20;
   localparam logic [7:0] OFS_DRIVE = 8'h40;
   localparam logic [7:0] OFS_LEVEL = 8'h50;
   localparam logic [7:0] OFS_PINVAL = 8'h60;
   localparam logic [7:0] OFS_PULLUP = 8'h70;
   localparam logic [7:0] OFS_ODRAIN = 8'h80;
   localparam logic [7:0] OFS_IRQEN = 8'h90;
   localparam logic [7:0] OFS_MODE_LO = 8'ha0;
   localparam logic [7:0] OFS_MODE_HI = 8'hb0;
   localparam logic [7:0] OFS_FILTER = 8'hc0;
   localparam logic [7:0] OFS_FLAGS = 8'hd0;
   // ==========================================================
   // Alias codes in address bits 3:2
   localparam logic [1:0] ALIAS_WRITE = 2'h0;
   localparam logic [1:0] ALIAS_SET = 2'h1;
   localparam logic [1:0] ALIAS_CLEAR = 2'h2;
   localparam logic [1:0] ALIAS_TOGGLE = 2'h3;
   // ==========================================================
   // Reset values
   localparam logic [31:0] RST_ALL_ONES = 32'hffffffff;
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   // ==========================================================
   // Interrupt mode codes {hi,lo}
   localparam logic [1:0] MODE_CHANGE = 2'h0;
   localparam logic [1:0] MODE_RISE = 2'h1;
   localparam logic [1:0] MODE_FALL = 2'h2;
   // ==========================================================
   // Pin group sizing
   localparam int PINS_PER_LINE = 8;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } gpc_bus_t;
endpackage
`default_nettype wire

// >>> testbench/gpc_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Wire level seen by the pins
module gpc_pins_model (
   input wire logic clk,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pin_pullup,
   input wire logic [31:0] ext_val,
   input wire logic [31:0] ext_oe,
   output logic [31:0] pin_in
);
   logic [31:0] junk_ff = 32'h0;
   always @(posedge clk) junk_ff <= ~junk_ff;
   // Driver, then outside part, then pull-up or noise
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_oe & ext_val) | (~ext_oe & (pin_pullup | junk_ff))));
endmodule
`default_nettype wire

// >>> testbench/gpc_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checker
module gpc_port_asserts #(
   parameter int NPINS = 32
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire gpc_pkg::gpc_bus_t bus,
   input wire logic [31:0] rdata,
   input wire logic [NPINS-1:0] pin_in,
   input wire logic [NPINS-1:0] pin_pullup,
   input wire logic [NPINS-1:0] periph_in,
   input wire logic [3:0] irq
);
   logic [2:0] quiet_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         quiet_ff <= 3'h0;
      else
         quiet_ff <= (bus.wr || !$stable(pin_in)) ? 3'h0 : quiet_ff + 3'(quiet_ff != 3'h7);
   end
   property p_rd_idle; !$past(bus.rd) |-> rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata set without read");
   property p_unmapped; $past(bus.rd && (bus.addr[7:4] == 4'h3 || bus.addr[7:4] > 4'hd)) |-> rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("reserved read not zero");
   property p_periph_in; periph_in == pin_in; endproperty
   a_periph_in: assert property (p_periph_in) else $error("periph_in not raw pin");
   property p_pull_hold; !$stable(pin_pullup) |-> $past(bus.wr); endproperty
   a_pull_hold: assert property (p_pull_hold) else $error("pull-up moved without write");
   property p_pull_wr; $past(bus.wr && bus.addr == gpc_pkg::OFS_PULLUP) |-> pin_pullup == $past(bus.wdata); endproperty
   a_pull_wr: assert property (p_pull_wr) else $error("pull-up not written");
   property p_quiet; quiet_ff > 3'h4 |-> (irq & ~$past(irq)) == 4'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("irq rose without cause");
   property p_sticky; (~irq & $past(irq)) != 4'h0 |-> $past(bus.wr); endproperty
   a_sticky: assert property (p_sticky) else $error("irq fell without write");
   property p_group; $past(bus.rd && bus.addr == gpc_pkg::OFS_FLAGS)
      |-> ($past(irq) & ~{|rdata[31:24], |rdata[23:16], |rdata[15:8], |rdata[7:0]}) == 4'h0; endproperty
   a_group: assert property (p_group) else $error("irq line without flag in group");
endmodule
bind gpc_port gpc_port_asserts #(.NPINS(NPINS)) u_chk (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
   .pin_in(pin_in), .pin_pullup(pin_pullup), .periph_in(periph_in), .irq(irq));
`default_nettype wire

// >>> testbench/tb_gpio_pin_controller.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench
module tb_gpio_pin_controller;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   gpc_pkg::gpc_bus_t bus = '0;
   logic [31:0] pv[8] = '{default: 32'h0};
   logic [31:0] ext_val = 32'h0;
   logic [31:0] rdata, pin_in, pin_out, pin_oe, pin_pullup, periph_in, lv, mlo, mhi, eo, ev;
   logic [3:0] irq;
   logic [31:0] exp_q[$];
   logic rd_ff = 1'b0;
   int bad_count = 0;
   int checks = 0;
   int seed = 76;
   always #20 clk = ~clk;
   gpc_port #(.NPINS(32)) i_dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .periph_in(periph_in), .irq(irq),
      .periph_out0(pv[0]), .periph_out1(pv[1]), .periph_out2(pv[2]), .periph_out3(pv[3]),
      .periph_oe0(pv[4]), .periph_oe1(pv[5]), .periph_oe2(pv[6]), .periph_oe3(pv[7]));
   gpc_pins_model i_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .ext_val(ext_val), .ext_oe(32'h1), .pin_in(pin_in));
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] want);
      checks++;
      bad_count += int'(seen !== want);
      if (seen !== want)
         $display("ERROR %s expected %h seen %h", s, want, seen);
   endtask
   task automatic complete_run(input logic late);
      bad_count += int'(late);
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Write when w is one, else read and note d as expected
   task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge clk) bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      if (!w)
         exp_q.push_back(d);
      @(posedge clk) bus <= '0;
      #1;
   endtask
   task automatic pin0(input logic v, input int n);
      @(posedge clk) ext_val[0] <= v;
      tick(n - 1);
   endtask
   always @(posedge clk)
   begin
      rd_ff <= bus.rd;
      if (rd_ff)
         check("rdata", rdata, exp_q.pop_front());
   end
   initial #80000 complete_run(1'b1);
   initial
   begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      // Reset values and a reserved place
      acc(8'h00, gpc_pkg::RST_ALL_ONES, 1'b0);
      acc(8'hc0, gpc_pkg::RST_ALL_ONES, 1'b0);
      acc(8'h30, 32'h0, 1'b0);
      lv = $random(seed);
      acc(8'h40, '1, 1'b1);
      acc(8'h50, lv, 1'b1);
      acc(8'h54, 32'h0000000f, 1'b1);
      acc(8'h58, 32'h000000f0, 1'b1);
      acc(8'h5c, 32'h0000ff00, 1'b1);
      lv = ((lv | 32'h0000000f) & 32'hffffff0f) ^ 32'h0000ff00;
      check("pin_out", pin_out, lv);
      check("pin_oe", pin_oe, '1);
      acc(8'h60, lv, 1'b0);
      acc(8'h70, '1, 1'b1);
      acc(8'h80, '1, 1'b1);
      check("pin_pullup", pin_pullup, '1);
      check("pin_oe_od", pin_oe, ~lv);
      // Outside part holds pin 0 low once it is released
      acc(8'h60, lv & 32'hfffffffe, 1'b0);
      acc(8'h80, 32'h0, 1'b1);
      acc(8'h00, 32'h0, 1'b1);
      mlo = $random(seed);
      mhi = $random(seed);
      acc(8'h10, mlo, 1'b1);
      acc(8'h20, mhi, 1'b1);
      @(posedge clk);
      for (int k = 0; k < 8; k++)
         pv[k] <= $random(seed);
      tick(1);
      for (int i = 0; i < 32; i++)
         {eo[i], ev[i]} = {pv[{1'b1, mhi[i], mlo[i]}][i], pv[{1'b0, mhi[i], mlo[i]}][i]};
      check("pin_oe_mux", pin_oe, eo);
      check("pin_out_mux", pin_out & eo, ev & eo);
      check("periph_in", periph_in, pin_in);
      acc(8'h60, 32'h0, 1'b0);
      acc(8'h00, '1, 1'b1);
      acc(8'h40, 32'h0, 1'b1);
      acc(8'hc0, 32'h0, 1'b1);
      acc(8'h90, 32'h1, 1'b1);
      // Every mode on a rise and a fall
      for (int m = 3; m >= 0; m--)
      begin
         acc(8'ha0, {32{m[0]}}, 1'b1);
         acc(8'hb0, {32{m[1]}}, 1'b1);
         acc(8'hd0, '1, 1'b1);
         pin0(1'b1, 6);
         check("irq_rise", irq, {3'h0, m < 2});
         acc(8'h90, 32'h0, 1'b1);
         check("irq_masked", irq, 4'h0);
         acc(8'h90, 32'h1, 1'b1);
         acc(8'hd0, {31'h0, m < 2}, 1'b0);
         acc(8'hd0, '1, 1'b1);
         pin0(1'b0, 6);
         check("irq_fall", irq, {3'h0, m == 0 || m == 2});
      end
      // Short pulses with and without filter
      for (int f = 0; f < 3; f++)
      begin
         acc(8'hc0, {31'h0, f > 0}, 1'b1);
         acc(8'hd0, '1, 1'b1);
         pin0(1'b1, 1 + int'(f == 2));
         pin0(1'b0, 6);
         check("irq_pulse", irq, {3'h0, f != 1});
      end
      complete_run(1'b0);
   end
endmodule
`default_nettype wire
